// file: core/bbo_pkg.sv
// shared types and constants for the byte/bit execute block
`default_nettype none
package bbo_pkg;
  // ****************************************
  // widths
  // ****************************************
  localparam int DW  = 8;
  localparam int FAW = 7;
  localparam int BW  = 3;
  localparam int AW  = 4;
  localparam int XW  = 32;
  localparam int CW  = 16;

  // ****************************************
  // operations
  // ****************************************
  typedef enum logic [3:0] {
    BBO_NOP,
    BBO_ADD_IMMEDIATE_ACC,
    BBO_ADD_ACC_FILE,
    BBO_AND_IMMEDIATE_ACC,
    BBO_AND_ACC_FILE,
    BBO_BIT_CLEAR_OP,
    BBO_BIT_SET_OP,
    BBO_TEST_BIT_SKIP_CLEAR,
    BBO_TEST_BIT_SKIP_SET,
    BBO_WATCHDOG_KICK
  } bbo_op_t;

  typedef struct packed {
    bbo_op_t          op;
    logic [FAW-1:0]   faddr;
    logic [BW-1:0]    bsel;
    logic             dest_file;
    logic [DW-1:0]    imm;
    logic [DW-1:0]    fdata;
  } bbo_instr_t;

  typedef struct packed {
    logic c;
    logic nibble_overflow_bit;
    logic z;
  } bbo_flags_t;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [AW-1:0] ADDR_CTRL    = 4'h0;
  localparam logic [AW-1:0] ADDR_STATUS  = 4'h4;
  localparam logic [AW-1:0] ADDR_SKIPCNT = 4'h8;
  localparam int CTRL_EN_BIT   = 0;
  localparam int ST_ACC_LSB    = 0;
  localparam int ST_C_BIT      = 8;
  localparam int ST_NOV_BIT    = 9;
  localparam int ST_Z_BIT      = 10;
  localparam int ST_TO_BIT     = 11;
  localparam int ST_PD_BIT     = 12;
  localparam int ST_SKIP_BIT   = 13;
  localparam logic       CTRL_EN_RST = 1'b1;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int CARRY_BIT  = 8;
  localparam int NIBBLE_W   = 4;
endpackage
`default_nettype wire

// file: core/bbo_alu.sv
// combinational result and flag logic of the execute block
`default_nettype none
module bbo_alu (
  input  wire bbo_pkg::bbo_op_t        op,
  input  wire logic [bbo_pkg::DW-1:0]  acc,
  input  wire logic [bbo_pkg::DW-1:0]  opnd,
  input  wire logic [bbo_pkg::BW-1:0]  bsel,
  output logic [bbo_pkg::DW-1:0]       result,
  output logic                         carry,
  output logic                         nibble_carry,
  output logic                         zero
);
  // ****************************************
  // bit mask decode
  // ****************************************
  function automatic logic [bbo_pkg::DW-1:0] bit_mask(
    input logic [bbo_pkg::BW-1:0] b);
    bit_mask = bbo_pkg::DW'(1) << b;
  endfunction

  logic [bbo_pkg::DW:0]       sum;
  logic [bbo_pkg::NIBBLE_W:0] nsum;

  always_comb begin
    sum  = {1'b0, acc} + {1'b0, opnd};
    nsum = {1'b0, acc[bbo_pkg::NIBBLE_W-1:0]}
         + {1'b0, opnd[bbo_pkg::NIBBLE_W-1:0]};
    case (op)
      bbo_pkg::BBO_ADD_IMMEDIATE_ACC,
      bbo_pkg::BBO_ADD_ACC_FILE: result = sum[bbo_pkg::DW-1:0];
      bbo_pkg::BBO_AND_IMMEDIATE_ACC,
      bbo_pkg::BBO_AND_ACC_FILE: result = acc & opnd;
      bbo_pkg::BBO_BIT_CLEAR_OP: result = opnd & ~bit_mask(bsel);
      bbo_pkg::BBO_BIT_SET_OP:   result = opnd | bit_mask(bsel);
      default:                   result = opnd;
    endcase
    carry        = sum[bbo_pkg::CARRY_BIT];
    nibble_carry = nsum[bbo_pkg::NIBBLE_W];
    zero         = (result == '0);
  end
endmodule
`default_nettype wire

// file: core/bbo_execute.sv
// byte and bit operation execute stage with AXI4-Lite status port
// Notes on behaviour
// - add-immediate sums acc and an 8-bit literal into acc, with C, DC, Z.
// - add-acc-file adds acc to a file register; dest 0 to acc, 1 to file.
// - and-immediate ANDs acc with a literal into acc, touching only Z.
// - and-acc-file ANDs acc with a file register to acc or file, only Z.
// - bit-clear forces the chosen bit of the file register low, no flags.
// - bit-set forces the chosen bit of the file register high, no flags.
// - skip-if-clear discards the next instruction when the bit is zero.
// - skip-if-set discards the next instruction when the bit is one.
// - watchdog kick loads the watchdog counter with zero.
// - watchdog kick also clears the watchdog prescaler.
// - watchdog kick sets the timeout and powerdown status bits to one.
`default_nettype none
module bbo_execute (
  input  wire logic                       aclk,
  input  wire logic                       aresetn,
  input  wire logic                       issue_valid,
  input  wire bbo_pkg::bbo_instr_t        instr,
  input  wire logic                       timeout_evt,
  input  wire logic                       sleep_evt,
  output var  logic                       file_we,
  output var  logic [bbo_pkg::FAW-1:0]    file_waddr,
  output var  logic [bbo_pkg::DW-1:0]     file_wdata,
  output var  logic [bbo_pkg::DW-1:0]     acc,
  output var  bbo_pkg::bbo_flags_t        flags,
  output var  logic                       timeout_n,
  output var  logic                       powerdown_n,
  output var  logic                       wdt_clear,
  output var  logic                       skip_taken,
  input  wire logic [bbo_pkg::AW-1:0]     s_axi_awaddr,
  input  wire logic                       s_axi_awvalid,
  output var  logic                       s_axi_awready,
  input  wire logic [bbo_pkg::XW-1:0]     s_axi_wdata,
  input  wire logic [3:0]                 s_axi_wstrb,
  input  wire logic                       s_axi_wvalid,
  output var  logic                       s_axi_wready,
  output var  logic [1:0]                 s_axi_bresp,
  output var  logic                       s_axi_bvalid,
  input  wire logic                       s_axi_bready,
  input  wire logic [bbo_pkg::AW-1:0]     s_axi_araddr,
  input  wire logic                       s_axi_arvalid,
  output var  logic                       s_axi_arready,
  output var  logic [bbo_pkg::XW-1:0]     s_axi_rdata,
  output var  logic [1:0]                 s_axi_rresp,
  output var  logic                       s_axi_rvalid,
  input  wire logic                       s_axi_rready
);
  // ****************************************
  // issue and operand select
  // ****************************************
  logic                      ctrl_en_reg;
  logic [bbo_pkg::CW-1:0]    skip_cnt_reg;
  logic                      take;
  logic                      squash;
  logic                      is_add;
  logic                      is_and;
  logic                      imm_op;
  logic                      tbit;
  logic [bbo_pkg::DW-1:0]    opnd;
  logic [bbo_pkg::DW-1:0]    res;
  logic                      c_n;
  logic                      dc_n;
  logic                      z_n;

  assign take   = issue_valid && ctrl_en_reg && !skip_taken;
  assign squash = issue_valid && skip_taken;
  assign is_add = instr.op == bbo_pkg::BBO_ADD_IMMEDIATE_ACC
               || instr.op == bbo_pkg::BBO_ADD_ACC_FILE;
  assign is_and = instr.op == bbo_pkg::BBO_AND_IMMEDIATE_ACC
               || instr.op == bbo_pkg::BBO_AND_ACC_FILE;
  assign imm_op = instr.op == bbo_pkg::BBO_ADD_IMMEDIATE_ACC
               || instr.op == bbo_pkg::BBO_AND_IMMEDIATE_ACC;
  assign opnd   = imm_op ? instr.imm : instr.fdata;
  assign tbit   = instr.fdata[instr.bsel];

  bbo_alu u_alu (
    .op           (instr.op),
    .acc          (acc),
    .opnd         (opnd),
    .bsel         (instr.bsel),
    .result       (res),
    .carry        (c_n),
    .nibble_carry (dc_n),
    .zero         (z_n)
  );

  // ****************************************
  // accumulator
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      acc <= '0;
    end else if (take && (imm_op || ((is_add || is_and)
                 && !instr.dest_file))) begin
      acc <= res;
    end
  end

  // ****************************************
  // file register write port
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      file_we    <= 1'b0;
      file_waddr <= '0;
      file_wdata <= '0;
    end else begin
      file_we    <= take && (((instr.op == bbo_pkg::BBO_ADD_ACC_FILE
                    || instr.op == bbo_pkg::BBO_AND_ACC_FILE)
                    && instr.dest_file)
                    || instr.op == bbo_pkg::BBO_BIT_CLEAR_OP
                    || instr.op == bbo_pkg::BBO_BIT_SET_OP);
      file_waddr <= instr.faddr;
      file_wdata <= res;
    end
  end

  // ****************************************
  // arithmetic flags
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags <= '0;
    end else if (take && is_add) begin
      flags.c                   <= c_n;
      flags.nibble_overflow_bit <= dc_n;
      flags.z                   <= z_n;
    end else if (take && is_and) begin
      flags.z <= z_n;
    end
  end

  // ****************************************
  // conditional skip
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      skip_taken <= 1'b0;
    end else if (take) begin
      skip_taken <= (instr.op == bbo_pkg::BBO_TEST_BIT_SKIP_CLEAR && !tbit)
                 || (instr.op == bbo_pkg::BBO_TEST_BIT_SKIP_SET && tbit);
    end else if (squash) begin
      skip_taken <= 1'b0;
    end
  end

  // ****************************************
  // watchdog kick and status bits
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wdt_clear <= 1'b0;
    end else begin
      wdt_clear <= take && instr.op == bbo_pkg::BBO_WATCHDOG_KICK;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timeout_n   <= 1'b1;
      powerdown_n <= 1'b1;
    end else if (take && instr.op == bbo_pkg::BBO_WATCHDOG_KICK) begin
      timeout_n   <= 1'b1;
      powerdown_n <= 1'b1;
    end else begin
      if (timeout_evt) timeout_n <= 1'b0;
      if (sleep_evt) powerdown_n <= 1'b0;
    end
  end

  // ****************************************
  // axi4-lite write channel
  // ****************************************
  logic                     aw_got_reg;
  logic                     w_got_reg;
  logic [bbo_pkg::AW-1:0]   awaddr_reg;
  logic [bbo_pkg::XW-1:0]   wdata_reg;
  logic                     wstrb0_reg;
  logic                     wr_go;

  assign wr_go = aw_got_reg && w_got_reg && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_reg    <= 1'b0;
      s_axi_awready <= 1'b1;
      awaddr_reg    <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_got_reg    <= 1'b1;
      s_axi_awready <= 1'b0;
      awaddr_reg    <= s_axi_awaddr;
    end else if (s_axi_bvalid && s_axi_bready) begin
      aw_got_reg    <= 1'b0;
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_got_reg    <= 1'b0;
      s_axi_wready <= 1'b1;
      wdata_reg    <= '0;
      wstrb0_reg   <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_got_reg    <= 1'b1;
      s_axi_wready <= 1'b0;
      wdata_reg    <= s_axi_wdata;
      wstrb0_reg   <= s_axi_wstrb[0];
    end else if (s_axi_bvalid && s_axi_bready) begin
      w_got_reg    <= 1'b0;
      s_axi_wready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= bbo_pkg::RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (awaddr_reg == bbo_pkg::ADDR_CTRL
                    || awaddr_reg == bbo_pkg::ADDR_SKIPCNT)
                    ? bbo_pkg::RESP_OKAY : bbo_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_en_reg <= bbo_pkg::CTRL_EN_RST;
    end else if (wr_go && wstrb0_reg
                 && awaddr_reg == bbo_pkg::ADDR_CTRL) begin
      ctrl_en_reg <= wdata_reg[bbo_pkg::CTRL_EN_BIT];
    end
  end

  // count of discarded instructions; a discard in the same cycle as a clear leaves a count of one
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      skip_cnt_reg <= '0;
    end else if (wr_go && awaddr_reg == bbo_pkg::ADDR_SKIPCNT) begin
      skip_cnt_reg <= squash ? bbo_pkg::CW'(1) : '0;
    end else if (squash) begin
      skip_cnt_reg <= skip_cnt_reg + bbo_pkg::CW'(1);
    end
  end

  // ****************************************
  // axi4-lite read channel
  // ****************************************
  function automatic logic [bbo_pkg::XW-1:0] status_word();
    logic [bbo_pkg::XW-1:0] w;
    w = '0;
    w[bbo_pkg::ST_ACC_LSB +: bbo_pkg::DW] = acc;
    w[bbo_pkg::ST_C_BIT]    = flags.c;
    w[bbo_pkg::ST_NOV_BIT]  = flags.nibble_overflow_bit;
    w[bbo_pkg::ST_Z_BIT]    = flags.z;
    w[bbo_pkg::ST_TO_BIT]   = timeout_n;
    w[bbo_pkg::ST_PD_BIT]   = powerdown_n;
    w[bbo_pkg::ST_SKIP_BIT] = skip_taken;
    return w;
  endfunction

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= bbo_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= bbo_pkg::RESP_OKAY;
      case (s_axi_araddr)
        bbo_pkg::ADDR_CTRL:    s_axi_rdata <= bbo_pkg::XW'(ctrl_en_reg);
        bbo_pkg::ADDR_STATUS:  s_axi_rdata <= status_word();
        bbo_pkg::ADDR_SKIPCNT: s_axi_rdata <= bbo_pkg::XW'(skip_cnt_reg);
        default: begin
          s_axi_rdata <= '0;
          s_axi_rresp <= bbo_pkg::RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  logic [bbo_pkg::DW:0] chk_sum;
  assign chk_sum = {1'b0, acc} + {1'b0, opnd};

  a_add_imm_acc: assert property (
    take && instr.op == bbo_pkg::BBO_ADD_IMMEDIATE_ACC |=>
      acc == $past(chk_sum[bbo_pkg::DW-1:0]) && !file_we)
    else $error("add immediate result wrong");
  a_add_file_dest: assert property (
    take && instr.op == bbo_pkg::BBO_ADD_ACC_FILE && instr.dest_file |=>
      file_we && file_wdata == $past(chk_sum[bbo_pkg::DW-1:0])
      && acc == $past(acc))
    else $error("add to file destination wrong");
  a_and_imm_z: assert property (
    take && instr.op == bbo_pkg::BBO_AND_IMMEDIATE_ACC |=>
      acc == ($past(acc) & $past(instr.imm)) && flags.c == $past(flags.c)
      && flags.z == (acc == '0))
    else $error("and immediate wrong");
  a_and_file_acc: assert property (
    take && instr.op == bbo_pkg::BBO_AND_ACC_FILE && !instr.dest_file |=>
      acc == ($past(acc) & $past(instr.fdata)) && !file_we
      && flags.nibble_overflow_bit == $past(flags.nibble_overflow_bit))
    else $error("and with file wrong");
  a_bit_clear_op: assert property (
    take && instr.op == bbo_pkg::BBO_BIT_CLEAR_OP |=>
      file_we && !file_wdata[$past(instr.bsel)] && flags == $past(flags))
    else $error("bit clear wrong");
  a_bit_set_op: assert property (
    take && instr.op == bbo_pkg::BBO_BIT_SET_OP |=>
      file_we && file_wdata[$past(instr.bsel)] && flags == $past(flags))
    else $error("bit set wrong");
  a_skip_clear_test: assert property (
    take && instr.op == bbo_pkg::BBO_TEST_BIT_SKIP_CLEAR |=>
      skip_taken == !$past(tbit) && flags == $past(flags))
    else $error("skip if clear wrong");
  a_skip_set_test: assert property (
    take && instr.op == bbo_pkg::BBO_TEST_BIT_SKIP_SET |=>
      skip_taken == $past(tbit) && flags == $past(flags))
    else $error("skip if set wrong");
  a_squash_no_effect: assert property (
    squash |=> !file_we && !wdt_clear && acc == $past(acc) && !skip_taken)
    else $error("discarded instruction had an effect");
  a_wdt_kick_pulse: assert property (
    take && instr.op == bbo_pkg::BBO_WATCHDOG_KICK |=>
      wdt_clear && timeout_n && powerdown_n)
    else $error("watchdog kick wrong");
  a_add_carry_flags: assert property (
    take && is_add |=> flags.c == $past(chk_sum[bbo_pkg::CARRY_BIT])
      && flags.z == ($past(chk_sum[bbo_pkg::DW-1:0]) == '0))
    else $error("add flags wrong");

  c_skip_then_squash: cover property (skip_taken ##1 squash);
  c_add_carry_out: cover property (take && is_add && c_n ##1 flags.c);
  c_wdt_kick: cover property (wdt_clear ##1 !wdt_clear);
  c_axi_write: cover property (s_axi_bvalid && s_axi_bready);
endmodule
`default_nettype wire

// file: verification/bbo_file_model.sv
// file register model facing the execute block
`default_nettype none
module bbo_file_model (
  input  wire logic                      aclk,
  input  wire logic [bbo_pkg::FAW-1:0]   faddr,
  input  wire logic                      file_we,
  input  wire logic [bbo_pkg::FAW-1:0]   file_waddr,
  input  wire logic [bbo_pkg::DW-1:0]    file_wdata,
  output logic      [bbo_pkg::DW-1:0]    fdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [bbo_pkg::DW-1:0] mem [128];
  // known start pattern, mirrored by the bench
  initial begin
    for (int i = 0; i < 128; i++) begin
      mem[i] = 8'((i * 3 + 1) % 256);
    end
  end
  always @(posedge aclk) begin
    if (file_we) begin
      mem[file_waddr] <= file_wdata;
    end
  end
  assign fdata = mem[faddr];
endmodule
`default_nettype wire

// file: verification/bbo_tb.sv
// self-checking bench for the byte and bit execute block
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // signals
  // ****************************************
  logic                aclk, aresetn, issue_valid, timeout_evt, sleep_evt;
  logic                file_we, timeout_n, powerdown_n, wdt_clear, skip_taken;
  logic [6:0]          file_waddr, i_fa;
  logic [7:0]          file_wdata, acc, fdata, i_im;
  logic [2:0]          i_bs;
  logic                i_d;
  bbo_pkg::bbo_flags_t flags;
  bbo_pkg::bbo_op_t    i_op;
  bbo_pkg::bbo_instr_t instr;
  logic                s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic                s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic                s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic                s_axi_rready;
  logic [3:0]          s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0]         s_axi_wdata, s_axi_rdata, r;
  logic [1:0]          s_axi_bresp, s_axi_rresp;
  int                  fails, n_tests, seed, i, k, cnt;
  int                  ea, ec, ecn, ez, ewe, ewa, ewd, es, ewdc, eto, epd;
  int                  ctl_en;
  int                  emem [128];

  assign instr = '{op: i_op, faddr: i_fa, bsel: i_bs, dest_file: i_d,
                   imm: i_im, fdata: fdata};

  bbo_execute dut_u (.aclk, .aresetn, .issue_valid, .instr, .timeout_evt,
    .sleep_evt, .file_we, .file_waddr, .file_wdata, .acc, .flags,
    .timeout_n, .powerdown_n, .wdt_clear, .skip_taken, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

  bbo_file_model fm_u (.aclk, .faddr(i_fa), .file_we, .file_waddr,
    .file_wdata, .fdata);

  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  // ****************************************
  // checking and model
  // ****************************************
  task report_and_stop();
    if (fails == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] seen, input logic [31:0] ex);
    n_tests++;
    if (seen !== ex) begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, ex, seen);
    end
  endtask

  task chk_all();
    chk("acc", acc, ea);
    chk("flags", flags, ec * 4 + ecn * 2 + ez);
    chk("file_we", file_we, ewe);
    if (ewe) chk("file_wr", {file_waddr, file_wdata}, ewa * 256 + ewd);
    chk("skip_taken", skip_taken, es);
    chk("wdt_clear", wdt_clear, ewdc);
    chk("status_n", {timeout_n, powerdown_n}, eto * 2 + epd);
  endtask

  task step(input int v, op, fa, bs, d, im, te, se);
    int f, o, s, rr;
    ewe = 0;
    ewdc = 0;
    if (te) eto = 0;
    if (se) epd = 0;
    if (!v) return;
    if (es) begin
      es = 0;
      cnt++;
      return;
    end
    if (!ctl_en) return;
    f = emem[fa];
    o = (op == 1 || op == 3) ? im : f;
    rr = -1;
    case (op)
      1, 2: begin
        s = ea + o;
        ec = s > 255;
        ecn = (ea % 16 + o % 16) > 15;
        rr = s % 256;
      end
      3, 4: rr = ea & o;
      5: rr = f & ~(1 << bs);
      6: rr = f | (1 << bs);
      7: es = ((f >> bs) & 1) == 0;
      8: es = ((f >> bs) & 1) == 1;
      9: begin
        ewdc = 1;
        eto = 1;
        epd = 1;
      end
      default: ;
    endcase
    if (op <= 4 && rr >= 0) ez = rr == 0;
    if (rr >= 0 && (op >= 5 || (op % 2 == 0 && d))) begin
      ewe = 1;
      ewa = fa;
      ewd = rr;
      emem[fa] = rr;
    end else if (rr >= 0) ea = rr;
  endtask

  // ****************************************
  // drivers
  // ****************************************
  task cyc(input int v, op = 0, fa = 0, bs = 0, d = 0, im = 0, te = 0,
           se = 0);
    @(posedge aclk);
    issue_valid <= v[0];
    i_op <= bbo_pkg::bbo_op_t'(op[3:0]);
    i_fa <= fa[6:0];
    i_bs <= bs[2:0];
    i_d <= d[0];
    i_im <= im[7:0];
    timeout_evt <= te[0];
    sleep_evt <= se[0];
    @(negedge aclk);
    chk_all();
    step(v, op, fa, bs, d, im, te, se);
  endtask

  task axi_wr(input logic [3:0] a, input logic [31:0] d,
              input logic [1:0] er);
    int n;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && n < 100);
    chk("bresp", s_axi_bresp, er);
    s_axi_bready <= 1'b0;
  endtask

  task axi_rd(input logic [3:0] a, input logic [31:0] ed,
              input logic [1:0] er);
    int n;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && n < 100);
    chk("rdata", s_axi_rdata, ed);
    chk("rresp", s_axi_rresp, er);
    s_axi_rready <= 1'b0;
  endtask

  // ****************************************
  // sequence
  // ****************************************
  initial begin
    repeat (5000) @(posedge aclk);
    fails++;
    report_and_stop();
  end

  initial begin
    seed = 32'h2C0E;
    {aresetn, issue_valid, timeout_evt, sleep_evt, i_d} = 5'h00;
    {i_fa, i_im, i_bs, i_op} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready} = 2'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hF;
    for (i = 0; i < 128; i++) emem[i] = (i * 3 + 1) % 256;
    {ea, ec, ecn, ez, ewe, es, ewdc, cnt, fails, n_tests} = '0;
    {eto, epd, ctl_en} = {32'h1, 32'h1, 32'h1};
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    cyc(0);
    axi_rd(bbo_pkg::ADDR_CTRL, 32'h1, bbo_pkg::RESP_OKAY);
    cyc(1, 1, 0, 0, 0, 8'hFF);
    cyc(1, 1, 0, 0, 0, 8'h01);
    cyc(0);
    // both test polarities, both outcomes, follower issued back to back
    for (k = 0; k < 4; k++) begin
      cyc(1, 7 + k / 2, 5, (k % 2) * 4);
      cyc(1, 1, 0, 0, 0, 8'h10);
      cyc(0);
    end
    cyc(0, 0, 0, 0, 0, 0, 1, 1);
    cyc(1, 9);
    cyc(0, 0, 0, 0, 0, 0, 1, 0);
    cyc(1, 9, 0, 0, 0, 0, 1, 1);
    cyc(0);
    for (i = 0; i < 300; i++) begin
      r = $random(seed);
      cyc(1, r[3:0] % 9 + 1, r[10:4], r[13:11], r[14], r[22:15]);
      cyc(0, 0, 0, 0, 0, 0, r[25] & r[26], r[27] & r[28]);
    end
    axi_rd(bbo_pkg::ADDR_STATUS, ea | ec << 8 | ecn << 9 | ez << 10 |
           eto << 11 | epd << 12 | es << 13, bbo_pkg::RESP_OKAY);
    axi_rd(bbo_pkg::ADDR_SKIPCNT, cnt, bbo_pkg::RESP_OKAY);
    axi_wr(bbo_pkg::ADDR_SKIPCNT, 32'h0, bbo_pkg::RESP_OKAY);
    axi_rd(bbo_pkg::ADDR_SKIPCNT, 32'h0, bbo_pkg::RESP_OKAY);
    axi_wr(bbo_pkg::ADDR_STATUS, 32'hFFFF, bbo_pkg::RESP_SLVERR);
    axi_wr(4'hC, 32'h0, bbo_pkg::RESP_SLVERR);
    axi_rd(4'hC, 32'h0, bbo_pkg::RESP_SLVERR);
    axi_wr(bbo_pkg::ADDR_CTRL, 32'h0, bbo_pkg::RESP_OKAY);
    ctl_en = 0;
    cyc(1, 1, 0, 0, 0, 8'h33);
    cyc(0);
    axi_rd(bbo_pkg::ADDR_CTRL, 32'h0, bbo_pkg::RESP_OKAY);
    axi_wr(bbo_pkg::ADDR_CTRL, 32'h1, bbo_pkg::RESP_OKAY);
    ctl_en = 1;
    cyc(1, 1, 0, 0, 0, 8'h33);
    cyc(0);
    // enable is only written when the low strobe is set
    s_axi_wstrb <= 4'hE;
    axi_wr(bbo_pkg::ADDR_CTRL, 32'h0, bbo_pkg::RESP_OKAY);
    s_axi_wstrb <= 4'hF;
    axi_rd(bbo_pkg::ADDR_CTRL, 32'h1, bbo_pkg::RESP_OKAY);
    // plain no-op leaves every result alone
    cyc(1);
    cyc(0);
    report_and_stop();
  end
endmodule
`default_nettype wire
